//--- rtl/mpr_pkg.sv
// Function
// - Region lower bound is base bits 31:6 followed by six zero bits.
// - Shareability 00 none, 10 outer, 11 inner; software never writes 01.
// - Permission 00 priv rw; 01 rw both; 10 priv ro; 11 ro both.
// - Region upper bound is limit bits 31:6 followed by six one bits.
// - Attribute index 0-3 picks low indirection slots, 4-7 high slots.
// - Limit bit 0 enables the region and resets to zero.
// - Address, attribute and permission fields need no reset value.
// - Indirect limit word reaches the region named by the selector.
// - Indirect limit word decodes as CRn 0110, opc1 000, CRm 0011, opc2 001.
// - Direct base and limit words exist for regions 0 to 31.
// - Direct region n: opc1 00,n[4]; CRm 1,n[3:1]; opc2 n[0],00 for base, n[0],01 for limit.
// - Direct encodings at or above the region count are unallocated.
// - Privileged writes trap on write trap, reads trap on read trap.
// - Privileged direct base accesses trap when trap-control bit 10 is set.
// - Privileged indirect limit accesses trap when trap-control bit 6 set.
// - Indirect base word decodes as CRm 0011, opc2 000 via selector.
package mpr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_REGIONS = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 32;
  localparam int BOUND_W = 26;
  localparam logic [7:0] REGION_COUNT = 8'h10;

  // ****************************************
  // Move encodings
  // ****************************************
  localparam logic [3:0] COPROC_ID = 4'hf;
  localparam logic [3:0] CRN_REGION = 4'h6;
  localparam logic [2:0] OPC1_INDIRECT = 3'h0;
  localparam logic [3:0] CRM_INDIRECT = 4'h3;
  localparam logic [2:0] OPC2_BASE = 3'h0;
  localparam logic [2:0] OPC2_LIMIT = 3'h1;
  localparam logic [1:0] DIRECT_OPC1_HI = 2'h0;
  localparam logic [1:0] DIRECT_OPC2_BASE = 2'h0;
  localparam logic [1:0] DIRECT_OPC2_LIMIT = 2'h1;
  localparam int CRM_DIRECT_BIT = 3;
  localparam int TRAP_DIRECT_BIT = 10;
  localparam int TRAP_INDIRECT_BIT = 6;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int ADDR_LSB = 6;
  localparam logic [5:0] LOW_FILL = 6'h00;
  localparam logic [5:0] HIGH_FILL = 6'h3f;
  localparam logic [31:0] BASE_WMASK = 32'hffff_ffdf;
  localparam logic [31:0] LIMIT_WMASK = 32'hffff_ffce;
  localparam int SHARE_LSB = 3;
  localparam int PERM_LSB = 1;
  localparam int EXEC_NEVER_BIT = 0;
  localparam int ATTR_LSB = 1;
  localparam int EN_BIT = 0;
  localparam int ATTR_W = 8;
  localparam logic [1:0] SHARE_NONE = 2'h0;
  localparam logic [1:0] SHARE_OUTER = 2'h2;
  localparam logic [1:0] SHARE_INNER = 2'h3;

  typedef enum logic [2:0] {
    MPR_USER = 3'b001,
    MPR_PRIV = 3'b010,
    MPR_HYP = 3'b100
  } mpr_level_t;

endpackage : mpr_pkg

//--- rtl/mpr_region_match.sv
`timescale 1ns/1ps
module mpr_region_match (
  // Region bounds, packed per region
  input wire logic [mpr_pkg::NUM_REGIONS*mpr_pkg::BOUND_W-1:0] lo_flat,
  input wire logic [mpr_pkg::NUM_REGIONS*mpr_pkg::BOUND_W-1:0] hi_flat,
  input wire logic [mpr_pkg::NUM_REGIONS-1:0] region_en,
  // Lookup
  input wire logic [mpr_pkg::ADDR_W-1:0] addr,
  output logic hit,
  output logic [mpr_pkg::IDX_W-1:0] hit_idx
);

  logic [mpr_pkg::NUM_REGIONS-1:0] in_region;

  genvar g;
  generate
    for (g = 0; g < mpr_pkg::NUM_REGIONS; g++) begin : g_cmp
      logic [mpr_pkg::ADDR_W-1:0] lo_addr;
      logic [mpr_pkg::ADDR_W-1:0] hi_addr;
      assign lo_addr = {lo_flat[g*mpr_pkg::BOUND_W +: mpr_pkg::BOUND_W],
                        mpr_pkg::LOW_FILL};
      assign hi_addr = {hi_flat[g*mpr_pkg::BOUND_W +: mpr_pkg::BOUND_W],
                        mpr_pkg::HIGH_FILL};
      assign in_region[g] = region_en[g] && addr >= lo_addr &&
                            addr <= hi_addr;
    end
  endgenerate

  // Lowest-numbered region wins, so overlaps resolve deterministically
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = mpr_pkg::NUM_REGIONS - 1; i >= 0; i--) begin
      if (in_region[i]) begin
        hit = 1'b1;
        hit_idx = i[mpr_pkg::IDX_W-1:0];
      end
    end
  end

endmodule : mpr_region_match

//--- rtl/mpr_regs.sv
`timescale 1ns/1ps
module mpr_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Coprocessor move request
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_coproc,
  input wire logic [3:0] cp_crn,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire mpr_pkg::mpr_level_t cp_level,
  // Coprocessor move answer
  output logic cp_done,
  output logic cp_claim,
  output logic cp_undef,
  output logic cp_trap_hyp,
  output logic [31:0] cp_rdata,
  // System control state
  input wire logic hyp_implemented,
  input wire logic trap_vm_writes,
  input wire logic trap_vm_reads,
  input wire logic general_trap_enable,
  input wire logic [15:0] hypervisor_trap_control,
  input wire logic [7:0] region_selector,
  input wire logic [31:0] attribute_indirection_low,
  input wire logic [31:0] attribute_indirection_high,
  // Address check request
  input wire logic chk_valid,
  input wire logic [31:0] chk_addr,
  input wire logic chk_write,
  input wire logic chk_fetch,
  input wire mpr_pkg::mpr_level_t chk_level,
  // Address check answer
  output logic chk_done,
  output logic chk_hit,
  output logic chk_fault,
  output logic [mpr_pkg::IDX_W-1:0] chk_region,
  output logic [7:0] chk_attr,
  output logic [1:0] chk_shareability
);

  // ****************************************
  // Storage
  // ****************************************
  // Fields carry no reset; only the enables are cleared
  logic [31:0] base_mem [mpr_pkg::NUM_REGIONS];
  logic [31:0] limit_mem [mpr_pkg::NUM_REGIONS];
  logic [mpr_pkg::NUM_REGIONS-1:0] region_en;

  function automatic logic perm_ok(input logic [1:0] perm,
                                   input mpr_pkg::mpr_level_t lvl,
                                   input logic wr);
    logic ok;
    ok = 1'b1;
    case (lvl)
      mpr_pkg::MPR_USER: ok = perm[0] && !(wr && perm[1]);
      mpr_pkg::MPR_PRIV: ok = !(wr && perm[1]);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : perm_ok

  // ****************************************
  // Move decode
  // ****************************************
  logic acc_reg;
  logic is_ind;
  logic is_dir;
  logic want_limit;
  logic [4:0] dir_num;
  logic [7:0] tgt_num;
  logic in_range;
  logic [mpr_pkg::IDX_W-1:0] idx;
  logic vm_trap;
  logic ctl_trap;
  logic next_undef;
  logic next_trap;
  logic do_acc;
  logic [31:0] rd_word;

  always_comb begin
    acc_reg = cp_coproc == mpr_pkg::COPROC_ID &&
              cp_crn == mpr_pkg::CRN_REGION;
    is_ind = acc_reg && cp_opc1 == mpr_pkg::OPC1_INDIRECT &&
             cp_crm == mpr_pkg::CRM_INDIRECT &&
             (cp_opc2 == mpr_pkg::OPC2_BASE ||
              cp_opc2 == mpr_pkg::OPC2_LIMIT);
    is_dir = acc_reg && cp_opc1[2:1] == mpr_pkg::DIRECT_OPC1_HI &&
             cp_crm[mpr_pkg::CRM_DIRECT_BIT] &&
             (cp_opc2[1:0] == mpr_pkg::DIRECT_OPC2_BASE ||
              cp_opc2[1:0] == mpr_pkg::DIRECT_OPC2_LIMIT);
    dir_num = {cp_opc1[0], cp_crm[2:0], cp_opc2[2]};
    want_limit = is_ind ? cp_opc2 == mpr_pkg::OPC2_LIMIT :
                 cp_opc2[1:0] == mpr_pkg::DIRECT_OPC2_LIMIT;
    tgt_num = is_ind ? region_selector : {3'h0, dir_num};
    in_range = tgt_num < mpr_pkg::REGION_COUNT;
    idx = tgt_num[mpr_pkg::IDX_W-1:0];
  end

  always_comb begin
    next_undef = cp_valid && (is_ind || is_dir) &&
                 (cp_level == mpr_pkg::MPR_USER ||
                  (cp_level == mpr_pkg::MPR_PRIV && general_trap_enable) ||
                  (is_dir && !in_range));
    vm_trap = cp_write ? trap_vm_writes : trap_vm_reads;
    ctl_trap =
      (is_dir && hypervisor_trap_control[mpr_pkg::TRAP_DIRECT_BIT]) ||
      (is_ind && hypervisor_trap_control[mpr_pkg::TRAP_INDIRECT_BIT]);
    next_trap = cp_valid && (is_ind || is_dir) && !next_undef &&
                cp_level == mpr_pkg::MPR_PRIV && hyp_implemented &&
                (vm_trap || ctl_trap);
    // Out-of-range selector is ignored rather than corrupting a region
    do_acc = cp_valid && (is_ind || is_dir) && !next_undef &&
             !next_trap && in_range;
    rd_word = '0;
    if (in_range) begin
      rd_word = want_limit ?
                {limit_mem[idx][31:1], region_en[idx]} & mpr_pkg::LIMIT_WMASK
                | {31'h0, region_en[idx]} :
                base_mem[idx] & mpr_pkg::BASE_WMASK;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // fields left without reset
  always_ff @(posedge clock) begin
    if (do_acc && cp_write) begin
      if (want_limit) begin
        limit_mem[idx] <= cp_wdata & mpr_pkg::LIMIT_WMASK;
      end else begin
        base_mem[idx] <= cp_wdata & mpr_pkg::BASE_WMASK;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      region_en <= '0;
    end else if (do_acc && cp_write && want_limit) begin
      region_en[idx] <= cp_wdata[mpr_pkg::EN_BIT];
    end
  end

  // ****************************************
  // Move answer
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cp_done <= 1'b0;
      cp_claim <= 1'b0;
      cp_undef <= 1'b0;
      cp_trap_hyp <= 1'b0;
      cp_rdata <= '0;
    end else begin
      cp_done <= cp_valid;
      cp_claim <= cp_valid && (is_ind || is_dir);
      cp_undef <= next_undef;
      cp_trap_hyp <= next_trap;
      cp_rdata <= (do_acc && !cp_write) ? rd_word : '0;
    end
  end

  // ****************************************
  // Address check
  // ****************************************
  logic [mpr_pkg::NUM_REGIONS*mpr_pkg::BOUND_W-1:0] lo_flat;
  logic [mpr_pkg::NUM_REGIONS*mpr_pkg::BOUND_W-1:0] hi_flat;
  logic m_hit;
  logic [mpr_pkg::IDX_W-1:0] m_idx;

  genvar g;
  generate
    for (g = 0; g < mpr_pkg::NUM_REGIONS; g++) begin : g_flat
      assign lo_flat[g*mpr_pkg::BOUND_W +: mpr_pkg::BOUND_W] =
        base_mem[g][31:mpr_pkg::ADDR_LSB];
      assign hi_flat[g*mpr_pkg::BOUND_W +: mpr_pkg::BOUND_W] =
        limit_mem[g][31:mpr_pkg::ADDR_LSB];
    end
  endgenerate

  mpr_region_match u_match (
    .lo_flat(lo_flat),
    .hi_flat(hi_flat),
    .region_en(region_en),
    .addr(chk_addr),
    .hit(m_hit),
    .hit_idx(m_idx)
  );

  logic [1:0] hit_perm;
  logic hit_exec_never;
  logic [2:0] hit_attr_idx;
  logic [7:0] next_attr;
  logic next_fault;

  always_comb begin
    hit_perm = base_mem[m_idx][mpr_pkg::PERM_LSB +: 2];
    hit_exec_never = base_mem[m_idx][mpr_pkg::EXEC_NEVER_BIT];
    hit_attr_idx = limit_mem[m_idx][mpr_pkg::ATTR_LSB +: 3];
    if (hit_attr_idx[2]) begin
      next_attr = attribute_indirection_high[
        hit_attr_idx[1:0]*mpr_pkg::ATTR_W +: mpr_pkg::ATTR_W];
    end else begin
      next_attr = attribute_indirection_low[
        hit_attr_idx[1:0]*mpr_pkg::ATTR_W +: mpr_pkg::ATTR_W];
    end
    // execute-never on fetch
    // Misses fall to the default map: privileged passes, user faults
    if (m_hit) begin
      next_fault = !perm_ok(hit_perm, chk_level, chk_write && !chk_fetch) ||
                   (chk_fetch && hit_exec_never);
    end else begin
      next_fault = chk_level == mpr_pkg::MPR_USER;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chk_done <= 1'b0;
      chk_hit <= 1'b0;
      chk_fault <= 1'b0;
      chk_region <= '0;
      chk_attr <= '0;
      chk_shareability <= mpr_pkg::SHARE_NONE;
    end else begin
      chk_done <= chk_valid;
      chk_hit <= chk_valid && m_hit;
      chk_fault <= chk_valid && next_fault;
      chk_region <= m_hit ? m_idx : '0;
      chk_attr <= (chk_valid && m_hit) ? next_attr : '0;
      chk_shareability <= (chk_valid && m_hit) ?
        base_mem[m_idx][mpr_pkg::SHARE_LSB +: 2] : mpr_pkg::SHARE_NONE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] hit_lo;
  logic [31:0] hit_hi;
  assign hit_lo = {base_mem[m_idx][31:mpr_pkg::ADDR_LSB], mpr_pkg::LOW_FILL};
  assign hit_hi = {limit_mem[m_idx][31:mpr_pkg::ADDR_LSB],
                   mpr_pkg::HIGH_FILL};

  chk_en_reset: assert property (
    @(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> region_en == '0)
    else $error("region enables not cleared by reset");

  chk_user_denied: assert property (
    @(posedge clock) disable iff (sys_rst)
    cp_valid && (is_ind || is_dir) && cp_level == mpr_pkg::MPR_USER
    |=> cp_undef && !cp_trap_hyp && cp_rdata == '0)
    else $error("user level move not refused");

  chk_unalloc_undef: assert property (
    @(posedge clock) disable iff (sys_rst)
    cp_valid && is_dir && !in_range |=> cp_done && cp_undef)
    else $error("unallocated direct slot accepted");

  chk_direct_trap: assert property (
    @(posedge clock) disable iff (sys_rst)
    cp_valid && is_dir && in_range && cp_level == mpr_pkg::MPR_PRIV &&
    !general_trap_enable && hyp_implemented &&
    hypervisor_trap_control[mpr_pkg::TRAP_DIRECT_BIT]
    |=> cp_trap_hyp && !cp_undef)
    else $error("direct access not trapped");

  chk_indirect_trap: assert property (
    @(posedge clock) disable iff (sys_rst)
    cp_valid && is_ind && cp_level == mpr_pkg::MPR_PRIV &&
    !general_trap_enable && hyp_implemented &&
    hypervisor_trap_control[mpr_pkg::TRAP_INDIRECT_BIT] |=> cp_trap_hyp)
    else $error("indirect access not trapped");

  chk_vm_trap: assert property (
    @(posedge clock) disable iff (sys_rst)
    next_trap && cp_write |=> $stable(region_en))
    else $error("trapped write changed a region");

  chk_sel_read: assert property (
    @(posedge clock) disable iff (sys_rst)
    do_acc && is_ind && want_limit && !cp_write
    |=> cp_rdata[mpr_pkg::EN_BIT] == $past(region_en[idx]))
    else $error("indirect limit read wrong region");

  chk_match_bounds: assert property (
    @(posedge clock) disable iff (sys_rst)
    m_hit |-> chk_addr >= hit_lo && chk_addr <= hit_hi && region_en[m_idx])
    else $error("match outside region bounds");

  chk_exec_never: assert property (
    @(posedge clock) disable iff (sys_rst)
    chk_valid && chk_fetch && m_hit && hit_exec_never
    |=> chk_fault && chk_hit)
    else $error("fetch from execute-never region allowed");

  cov_direct_write: cover property (
    @(posedge clock) disable iff (sys_rst) do_acc && is_dir && cp_write);
  cov_indirect_read: cover property (
    @(posedge clock) disable iff (sys_rst) do_acc && is_ind && !cp_write);
  cov_trap: cover property (
    @(posedge clock) disable iff (sys_rst) next_trap);
  cov_hit_fault: cover property (
    @(posedge clock) disable iff (sys_rst) chk_valid && m_hit ##1 chk_fault);

endmodule : mpr_regs

//--- testbench/mpr_core_model.sv
`timescale 1ns/1ps
module mpr_core_model (
  // Clock
  input wire logic clock,
  // Move request towards the region registers
  output logic cp_valid,
  output logic cp_write,
  output logic [3:0] cp_coproc,
  output logic [3:0] cp_crn,
  output logic [2:0] cp_opc1,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_opc2,
  output logic [31:0] cp_wdata,
  output mpr_pkg::mpr_level_t cp_level
);
  // ****************************************
  // Idle state
  // ****************************************
  initial begin
    cp_valid = 1'b0;
    cp_write = 1'b0;
    cp_coproc = 4'h0;
    cp_crn = 4'h0;
    cp_opc1 = 3'h0;
    cp_crm = 4'h0;
    cp_opc2 = 3'h0;
    cp_wdata = 32'h0;
    cp_level = mpr_pkg::MPR_USER;
  end

  // ****************************************
  // One move, one cycle of valid
  // ****************************************
  // A gap cycle after each move keeps valid to one driver per time step
  task automatic move(input logic wr, input logic [3:0] cop,
                      input logic [3:0] crn, input logic [2:0] o1,
                      input logic [3:0] crm, input logic [2:0] o2,
                      input logic [31:0] wd, input mpr_pkg::mpr_level_t lv);
    @(negedge clock);
    cp_valid = 1'b1;
    cp_write = wr;
    cp_coproc = cop;
    cp_crn = crn;
    cp_opc1 = o1;
    cp_crm = crm;
    cp_opc2 = o2;
    cp_wdata = wd;
    cp_level = lv;
    @(negedge clock);
    cp_valid = 1'b0;
    // Stale data must not look valid
    cp_wdata = ~cp_wdata;
  endtask : move
endmodule : mpr_core_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cp_valid, cp_write, cp_done, cp_claim, cp_undef, cp_trap_hyp;
  logic [3:0] cp_coproc, cp_crn, cp_crm, chk_region;
  logic [2:0] cp_opc1, cp_opc2;
  logic [31:0] cp_wdata, cp_rdata, attr_lo, attr_hi, chk_addr;
  mpr_pkg::mpr_level_t cp_level, chk_level;
  logic hyp_impl, tvw, tvr, gte, chk_valid, chk_write, chk_fetch;
  logic [15:0] htc, ce, cs;
  logic [7:0] sel, chk_attr;
  logic chk_done, chk_hit, chk_fault;
  logic [1:0] chk_shareability;
  logic [34:0] cp_q[$];
  logic [15:0] ck_q[$];
  logic [31:0] bw[16], lw[16];
  int mismatches = 0;
  int checked = 0;
  localparam logic [34:0] OKW = {3'b100, 32'h0};
  localparam logic [34:0] UND = {3'b110, 32'h0};
  localparam logic [34:0] TRP = {3'b101, 32'h0};

  always #2.5 clock = ~clock;

  mpr_core_model i_mpr_core_model (.clock(clock), .cp_valid(cp_valid),
    .cp_write(cp_write), .cp_coproc(cp_coproc), .cp_crn(cp_crn),
    .cp_opc1(cp_opc1), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
    .cp_wdata(cp_wdata), .cp_level(cp_level));

  mpr_regs i_mpr_regs (.clock(clock), .sys_rst(sys_rst),
    .cp_valid(cp_valid), .cp_write(cp_write), .cp_coproc(cp_coproc),
    .cp_crn(cp_crn), .cp_opc1(cp_opc1), .cp_crm(cp_crm),
    .cp_opc2(cp_opc2), .cp_wdata(cp_wdata), .cp_level(cp_level),
    .cp_done(cp_done), .cp_claim(cp_claim), .cp_undef(cp_undef),
    .cp_trap_hyp(cp_trap_hyp), .cp_rdata(cp_rdata),
    .hyp_implemented(hyp_impl), .trap_vm_writes(tvw),
    .trap_vm_reads(tvr), .general_trap_enable(gte),
    .hypervisor_trap_control(htc), .region_selector(sel),
    .attribute_indirection_low(attr_lo),
    .attribute_indirection_high(attr_hi), .chk_valid(chk_valid),
    .chk_addr(chk_addr), .chk_write(chk_write), .chk_fetch(chk_fetch),
    .chk_level(chk_level), .chk_done(chk_done), .chk_hit(chk_hit),
    .chk_fault(chk_fault), .chk_region(chk_region), .chk_attr(chk_attr),
    .chk_shareability(chk_shareability));

  // ****************************************
  // Compare and monitor
  // ****************************************
  task automatic cmp(input string what, input logic [34:0] e,
                     input logic [34:0] s);
    checked++;
    if (e !== s) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  always @(negedge clock) begin
    if (cp_done === 1'b1) begin
      if (cp_q.size() == 0) cmp("move answer", 35'h0, 35'h1);
      else cmp("move answer", cp_q.pop_front(),
               {cp_claim, cp_undef, cp_trap_hyp, cp_rdata});
    end
    if (chk_done === 1'b1) begin
      cs = {chk_hit, chk_fault, chk_region, chk_attr, chk_shareability};
      ce = (ck_q.size() == 0) ? ~cs : ck_q.pop_front();
      // Shareability means nothing on a miss
      if (ce[15] === 1'b0) cs[1:0] = 2'h0;
      cmp("check answer", {19'h0, ce}, {19'h0, cs});
    end
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  function automatic logic [34:0] rd(input logic [31:0] v);
    return {3'b100, v};
  endfunction : rd

  task automatic mv(input logic wr, input logic [3:0] crn,
                    input logic [2:0] o1, input logic [3:0] crm,
                    input logic [2:0] o2, input logic [31:0] wd,
                    input mpr_pkg::mpr_level_t lv, input logic [34:0] e);
    cp_q.push_back(e);
    i_mpr_core_model.move(wr, mpr_pkg::COPROC_ID, crn, o1, crm, o2, wd, lv);
  endtask : mv

  task automatic dr(input logic wr, input logic [4:0] n, input logic lim,
                    input logic [31:0] wd, input mpr_pkg::mpr_level_t lv,
                    input logic [34:0] e);
    mv(wr, 4'h6, {2'b00, n[4]}, {1'b1, n[3:1]}, {n[0], 1'b0, lim}, wd, lv,
       e);
  endtask : dr

  task automatic ind(input logic wr, input logic lim, input logic [31:0] wd,
                     input mpr_pkg::mpr_level_t lv, input logic [34:0] e);
    mv(wr, 4'h6, 3'h0, 4'h3, {2'b00, lim}, wd, lv, e);
  endtask : ind

  task automatic ck(input logic [31:0] a, input logic wr, input logic fe,
                    input mpr_pkg::mpr_level_t lv, input logic [15:0] e);
    ck_q.push_back(e);
    @(negedge clock);
    chk_valid = 1'b1;
    chk_addr = a;
    chk_write = wr;
    chk_fetch = fe;
    chk_level = lv;
    @(negedge clock);
    chk_valid = 1'b0;
    chk_addr = ~chk_addr;
  endtask : ck

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin : main
    logic [31:0] v;
    logic [7:0] ab;
    logic [1:0] shr;
    logic f;
    mpr_pkg::mpr_level_t lv;
    {hyp_impl, tvw, tvr, gte, chk_valid, chk_write, chk_fetch} = 7'h0;
    htc = 16'h0;
    sel = 8'h0;
    chk_addr = 32'h0;
    chk_level = mpr_pkg::MPR_USER;
    v = $urandom(90);
    attr_lo = $urandom();
    attr_hi = $urandom();
    repeat (20) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    ck(32'h0000_1000, 1'b0, 1'b0, mpr_pkg::MPR_USER, 16'h4000);
    ck(32'h0000_1000, 1'b0, 1'b0, mpr_pkg::MPR_PRIV, 16'h0000);
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      bw[n] = $urandom();
      lw[n] = $urandom();
      dr(1'b1, n[4:0], 1'b0, bw[n], mpr_pkg::MPR_HYP, OKW);
      dr(1'b1, n[4:0], 1'b1, lw[n], mpr_pkg::MPR_HYP, OKW);
    end
    for (int n = 0; n < 16; n++) begin
      dr(1'b0, n[4:0], 1'b0, 32'h0, mpr_pkg::MPR_HYP,
         rd(bw[n] & mpr_pkg::BASE_WMASK));
      dr(1'b0, n[4:0], 1'b1, 32'h0, mpr_pkg::MPR_HYP,
         rd(lw[n] & 32'hffff_ffcf));
      dr(1'b1, n[4:0], 1'b1, 32'h0, mpr_pkg::MPR_HYP, OKW);
    end
    for (int n = 16; n < 32; n++) begin
      dr(1'b0, n[4:0], 1'b0, 32'h0, mpr_pkg::MPR_HYP, UND);
      dr(1'b1, n[4:0], 1'b1, 32'h1, mpr_pkg::MPR_PRIV, UND);
    end
    $display("test direct words done");
    sel = 8'($urandom_range(15, 0));
    v = $urandom() & 32'hffff_fffe;
    ind(1'b1, 1'b0, ~v, mpr_pkg::MPR_PRIV, OKW);
    ind(1'b1, 1'b1, v, mpr_pkg::MPR_PRIV, OKW);
    dr(1'b0, sel[4:0], 1'b0, 32'h0, mpr_pkg::MPR_HYP,
       rd(~v & 32'hffff_ffdf));
    dr(1'b0, sel[4:0], 1'b1, 32'h0, mpr_pkg::MPR_HYP,
       rd(v & 32'hffff_ffce));
    ind(1'b0, 1'b1, 32'h0, mpr_pkg::MPR_PRIV, rd(v & 32'hffff_ffce));
    sel = 8'($urandom_range(255, 16));
    ind(1'b0, 1'b1, 32'h0, mpr_pkg::MPR_HYP, OKW);
    sel = 8'h7;
    $display("test indirect words done");
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_USER, UND);
    ind(1'b1, 1'b0, 32'h0, mpr_pkg::MPR_USER, UND);
    gte = 1'b1;
    dr(1'b1, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, UND);
    dr(1'b1, 5'd7, 1'b0, 32'h40, mpr_pkg::MPR_HYP, OKW);
    {gte, hyp_impl, tvw} = 3'b011;
    dr(1'b1, 5'd7, 1'b0, 32'h80, mpr_pkg::MPR_PRIV, TRP);
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, rd(32'h40));
    {tvw, tvr} = 2'b01;
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, TRP);
    {hyp_impl, tvw} = 2'b01;
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, rd(32'h40));
    {hyp_impl, tvw, tvr} = 3'b100;
    htc = 16'h0400;
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, TRP);
    ind(1'b0, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, rd(32'h40));
    htc = 16'h0040;
    ind(1'b1, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, TRP);
    dr(1'b0, 5'd7, 1'b0, 32'h0, mpr_pkg::MPR_PRIV, rd(32'h40));
    htc = 16'hffff;
    {tvw, tvr} = 2'b11;
    ind(1'b0, 1'b0, 32'h0, mpr_pkg::MPR_HYP, rd(32'h40));
    {hyp_impl, tvw, tvr} = 3'b000;
    htc = 16'h0;
    mv(1'b0, 4'h5, 3'h0, 4'h3, 3'h0, 32'h0, mpr_pkg::MPR_HYP, 35'h0);
    cp_q.push_back(35'h0);
    i_mpr_core_model.move(1'b0, 4'he, 4'h6, 3'h0, 4'h3, 3'h0, 32'h0,
                          mpr_pkg::MPR_HYP);
    $display("test access control done");
    for (int i = 0; i < 8; i++) begin
      // only the three legal shareability codes are written
      shr = (i % 3 == 0) ? 2'h0 : ((i % 3 == 1) ? 2'h2 : 2'h3);
      ab = (i < 4) ? attr_lo[8*i +: 8] : attr_hi[8*(i-4) +: 8];
      dr(1'b1, 5'd2, 1'b0, {24'h10, 3'h0, shr, 3'h2}, mpr_pkg::MPR_HYP, OKW);
      dr(1'b1, 5'd2, 1'b1, {24'h1f, 2'h3, 2'h0, 3'(i), 1'b1},
         mpr_pkg::MPR_HYP, OKW);
      ck(32'h1000 + $urandom_range(4095, 0), 1'b0, 1'b0, mpr_pkg::MPR_HYP,
         {2'b10, 4'h2, ab, shr});
    end
    ck(32'h0000_0fff, 1'b0, 1'b0, mpr_pkg::MPR_PRIV, 16'h0);
    ck(32'h0000_2000, 1'b0, 1'b0, mpr_pkg::MPR_PRIV, 16'h0);
    ck(32'h0000_1000, 1'b0, 1'b0, mpr_pkg::MPR_USER,
       {2'b10, 4'h2, ab, shr});
    ck(32'h0000_1fff, 1'b0, 1'b0, mpr_pkg::MPR_USER,
       {2'b10, 4'h2, ab, shr});
    for (int pm = 0; pm < 4; pm++) begin
      dr(1'b1, 5'd2, 1'b0, {24'h10, 5'h02, 2'(pm), 1'b0},
         mpr_pkg::MPR_PRIV, OKW);
      for (int k = 0; k < 4; k++) begin
        lv = k[1] ? mpr_pkg::MPR_PRIV : mpr_pkg::MPR_USER;
        f = k[1] ? (k[0] & pm[1]) : (!pm[0] | (k[0] & pm[1]));
        ck(32'h1000 + $urandom_range(4095, 0), k[0], 1'b0, lv,
           {1'b1, f, 4'h2, ab, 2'h2});
      end
      ck(32'h0000_1040, 1'b0, 1'b1, mpr_pkg::MPR_PRIV,
         {2'b10, 4'h2, ab, 2'h2});
    end
    dr(1'b1, 5'd2, 1'b0, {24'h10, 5'h02, 2'h1, 1'b1}, mpr_pkg::MPR_PRIV, OKW);
    ck(32'h0000_1040, 1'b0, 1'b1, mpr_pkg::MPR_USER,
       {2'b11, 4'h2, ab, 2'h2});
    dr(1'b1, 5'd2, 1'b1, 32'h1fc0, mpr_pkg::MPR_PRIV, OKW);
    ck(32'h0000_1040, 1'b0, 1'b0, mpr_pkg::MPR_PRIV, 16'h0);
    $display("test address check done");
    repeat (4) @(negedge clock);
    if (cp_q.size() != 0 || ck_q.size() != 0) begin
      mismatches++;
      $display("MISMATCH answers left expected 0 seen %0d",
               cp_q.size() + ck_q.size());
    end
    summarize();
  end : main
endmodule : tb_top
